// File: core/tpo_core.sv
// Triggered pattern output control for port 0 (8 bits) and port 1 (6 bits)
// Assumes buffer data and timer events come from logic on i_clk
// Operation
// - Port-1 select bits 0..5 enable buffered output per port-1 output.
// - Reset clears port-1 select, both controls and port-0 modulation.
// - Port-0 control bit 7 enables port-0 triggered operation.
// - Port-0 control bit 6 picks external edge: 0 falling, 1 rising.
// - Port-0 control bit 5: 0 two 4-bit channels, 1 one 8-bit.
// - Port-0 control bit 4 makes the external pin a transfer trigger.
// - Trigger mapping by width and external select for both nibbles.
// - Port-0 selected, unmodulated, not inverted, disabled output drives zero.
// - Port-1 control: bit 7 enable, bit 5 width, others read zero.
// - Timer-c triggers port 1: low nibble, or all six bits.
// - Port-1 selected, not inverted, disabled output drives zero.
// - Modulation master picks plain or modulated output.
// - High-group bit modulates port-0 outputs 0, 2 and 4.
// - Low-group bit modulates port-0 outputs 1, 3 and 5.
// - Invert bit inverts the port-0 output waveform.
// - Modulating waveform comes from the modulating timer output.
// - Group and invert bits act only while master bit is one.
// - Modulation fields: master 7, high 6, low 5, invert 4.
// - Enabled port 0 copies buffer to latch; only selected bits drive.
`timescale 1ns/10ps
`default_nettype none
`include "tpo_defines.svh"

module tpo_core
(
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  input  wire logic                   i_sfr_wr,
  input  wire logic                   i_sfr_rd,
  input  wire logic [`TPO_ADDR_W-1:0] i_sfr_addr,
  input  wire logic [`TPO_DATA_W-1:0] i_sfr_wdata,
  output var  logic [`TPO_DATA_W-1:0] o_sfr_rdata,
  input  wire logic [`TPO_P0_W-1:0]   i_port0_buffer,
  input  wire logic [`TPO_P1_W-1:0]   i_port1_buffer,
  input  wire logic                   i_timer_a_event,
  input  wire logic                   i_timer_b_event,
  input  wire logic                   i_timer_c_event,
  input  wire logic                   i_ext_pin,
  input  wire logic                   i_mod_timer_out,
  output var  logic [`TPO_P0_W-1:0]   o_port0_out_bit,
  output var  logic [`TPO_P0_W-1:0]   o_port0_rtp_mode,
  output var  logic [`TPO_P1_W-1:0]   o_port1_out_bit,
  output var  logic [`TPO_P1_W-1:0]   o_port1_rtp_mode
);

  localparam int HI = `TPO_NIB_W;

  // Output stage for one port-0 bit under modulation settings
  function automatic logic mod_bit(input logic rtp,
                                   input logic master,
                                   input logic grp,
                                   input logic inv,
                                   input logic wave);
    logic r;
    r = rtp;
    if (master)
    begin
      if (grp)
        r = inv ? (~rtp & wave) : (rtp | wave);
      else
        r = inv ? ~rtp : rtp;
    end
    return r;
  endfunction

  tpo_pkg::tpo_byte_t           mod_ctl_reg;
  tpo_pkg::tpo_byte_t           mod_ctl_next;
  tpo_pkg::tpo_byte_t           ctl0_reg;
  tpo_pkg::tpo_byte_t           ctl0_next;
  tpo_pkg::tpo_byte_t           ctl1_reg;
  tpo_pkg::tpo_byte_t           ctl1_next;
  logic [`TPO_P0_W-1:0]         sel0_reg;
  logic [`TPO_P0_W-1:0]         sel0_next;
  logic [`TPO_P1_W-1:0]         sel1_reg;
  logic [`TPO_P1_W-1:0]         sel1_next;
  tpo_pkg::tpo_byte_t           rdata_reg;
  tpo_pkg::tpo_byte_t           rdata_next;
  logic [`TPO_P0_W-1:0]         latch0_reg;
  logic [`TPO_P0_W-1:0]         latch0_next;
  logic [`TPO_P1_W-1:0]         latch1_reg;
  logic [`TPO_P1_W-1:0]         latch1_next;
  logic [`TPO_P0_W-1:0]         out0_reg;
  logic [`TPO_P0_W-1:0]         out0_next;
  logic [`TPO_P1_W-1:0]         out1_reg;
  logic [`TPO_P1_W-1:0]         out1_next;
  logic [`TPO_P0_W-1:0]         rtp0_next;
  logic [`TPO_P0_W-1:0]         grp0;
  logic                         ext_event;
  logic                         en0;
  logic                         en1;
  logic                         wide1;
  logic                         master;
  logic                         inv0;
  tpo_pkg::tpo_p0_mode_e        mode0;

  assign en0    = ctl0_reg[`TPO_BIT_ENABLE];
  assign en1    = ctl1_reg[`TPO_BIT_ENABLE];
  assign wide1  = ctl1_reg[`TPO_BIT_WIDTH];
  assign master = mod_ctl_reg[`TPO_BIT_MOD_MASTER];
  assign inv0   = mod_ctl_reg[`TPO_BIT_INVERT];
  assign mode0  = tpo_pkg::tpo_p0_mode_e'({ctl0_reg[`TPO_BIT_WIDTH],
                                           ctl0_reg[`TPO_BIT_EXT_SEL]});

  tpo_edge_sync u_ext_sync
  (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_pin    (i_ext_pin),
    .i_rising (ctl0_reg[`TPO_BIT_EXT_EDGE]),
    .o_event  (ext_event)
  );

  // Register file; only defined bits are stored, so unused bits read zero
  always_comb
  begin
    mod_ctl_next = mod_ctl_reg;
    ctl0_next    = ctl0_reg;
    ctl1_next    = ctl1_reg;
    sel0_next    = sel0_reg;
    sel1_next    = sel1_reg;
    rdata_next   = rdata_reg;
    if (i_sfr_wr)
    begin
      unique case (i_sfr_addr)
        `TPO_ADDR_P0_MOD_CTL: mod_ctl_next = {i_sfr_wdata[7:4], 4'h0};
        `TPO_ADDR_P0_CTL:     ctl0_next    = {i_sfr_wdata[7:4], 4'h0};
        `TPO_ADDR_P1_CTL:     ctl1_next    = {i_sfr_wdata[7], 1'b0,
                                              i_sfr_wdata[5], 5'h00};
        `TPO_ADDR_P0_SEL:     sel0_next    = i_sfr_wdata;
        `TPO_ADDR_P1_SEL:     sel1_next    = i_sfr_wdata[5:0];
        default:              sel1_next    = sel1_reg;
      endcase
    end
    if (i_sfr_rd)
    begin
      unique case (i_sfr_addr)
        `TPO_ADDR_P0_MOD_CTL: rdata_next = mod_ctl_reg;
        `TPO_ADDR_P0_CTL:     rdata_next = ctl0_reg;
        `TPO_ADDR_P1_CTL:     rdata_next = ctl1_reg;
        `TPO_ADDR_P0_SEL:     rdata_next = sel0_reg;
        `TPO_ADDR_P1_SEL:     rdata_next = {2'b00, sel1_reg};
        default:              rdata_next = `TPO_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      mod_ctl_reg <= `TPO_RESET_BYTE;
      ctl0_reg    <= `TPO_RESET_BYTE;
      ctl1_reg    <= `TPO_RESET_BYTE;
      sel0_reg    <= '0;
      sel1_reg    <= '0;
      rdata_reg   <= `TPO_RESET_BYTE;
    end
    else
    begin
      mod_ctl_reg <= mod_ctl_next;
      ctl0_reg    <= ctl0_next;
      ctl1_reg    <= ctl1_next;
      sel0_reg    <= sel0_next;
      sel1_reg    <= sel1_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Buffer to latch transfer on the selected triggers
  always_comb
  begin
    latch0_next = latch0_reg;
    latch1_next = latch1_reg;
    if (en0)
    begin
      unique case (mode0)
        tpo_pkg::TPO_SPLIT_TIMER:
        begin
          if (i_timer_b_event)
            latch0_next[`TPO_P0_W-1:HI] = i_port0_buffer[`TPO_P0_W-1:HI];
          if (i_timer_a_event)
            latch0_next[HI-1:0] = i_port0_buffer[HI-1:0];
        end
        tpo_pkg::TPO_SPLIT_EXT:
        begin
          if (i_timer_a_event)
            latch0_next[`TPO_P0_W-1:HI] = i_port0_buffer[`TPO_P0_W-1:HI];
          if (ext_event)
            latch0_next[HI-1:0] = i_port0_buffer[HI-1:0];
        end
        tpo_pkg::TPO_WIDE_TIMER:
        begin
          if (i_timer_a_event)
            latch0_next = i_port0_buffer;
        end
        tpo_pkg::TPO_WIDE_EXT:
        begin
          if (ext_event)
            latch0_next = i_port0_buffer;
        end
      endcase
    end
    if (en1 && i_timer_c_event)
    begin
      if (wide1)
        latch1_next = i_port1_buffer;
      else
        latch1_next[HI-1:0] = i_port1_buffer[HI-1:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      latch0_reg <= '0;
      latch1_reg <= '0;
    end
    else
    begin
      latch0_reg <= latch0_next;
      latch1_reg <= latch1_next;
    end
  end

  // Pins follow the new latch in the same edge; wave gains one cycle delay
  assign rtp0_next = sel0_reg & latch0_next & {`TPO_P0_W{en0}};

  genvar gi;
  generate
    for (gi = 0; gi < `TPO_P0_W; gi++)
    begin : g_p0
      if (gi < 6)
      begin : g_grp
        if (gi % 2 == 0)
        begin : g_hi
          assign grp0[gi] = mod_ctl_reg[`TPO_BIT_MOD_HIGH];
        end
        else
        begin : g_lo
          assign grp0[gi] = mod_ctl_reg[`TPO_BIT_MOD_LOW];
        end
      end
      else
      begin : g_none
        assign grp0[gi] = 1'b0;
      end
      assign out0_next[gi] = mod_bit(rtp0_next[gi], master, grp0[gi],
                                     inv0, i_mod_timer_out);
    end
  endgenerate

  always_comb
  begin
    out1_next = sel1_reg & latch1_next & {`TPO_P1_W{en1}};
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      out0_reg <= '0;
      out1_reg <= '0;
    end
    else
    begin
      out0_reg <= out0_next;
      out1_reg <= out1_next;
    end
  end

  assign o_sfr_rdata      = rdata_reg;
  assign o_port0_out_bit  = out0_reg;
  assign o_port1_out_bit  = out1_reg;
  assign o_port0_rtp_mode = sel0_reg;
  assign o_port1_rtp_mode = sel1_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  reset_clears_a: assert property (disable iff (1'b0)
    i_reset |-> (mod_ctl_reg == 8'h00 && ctl0_reg == 8'h00 &&
                 ctl1_reg == 8'h00 && sel1_reg == 6'h00))
    else $error("control registers not cleared by reset");
  sel1_write_a: assert property (
    (i_sfr_wr && i_sfr_addr == `TPO_ADDR_P1_SEL) |=>
      o_port1_rtp_mode == $past(i_sfr_wdata[5:0]))
    else $error("port1 select not written");
  ctl1_read_a: assert property (
    (i_sfr_rd && i_sfr_addr == `TPO_ADDR_P1_CTL) |=>
      (o_sfr_rdata & 8'h5F) == 8'h00)
    else $error("port1 control unused bits not zero");
  p0_off_zero_a: assert property (
    (!en0 && !master) |=> o_port0_out_bit == 8'h00)
    else $error("disabled port0 output not zero");
  p1_off_zero_a: assert property (
    !en1 |=> o_port1_out_bit == 6'h00)
    else $error("disabled port1 output not zero");
  p0_hold_a: assert property (
    !en0 |=> latch0_reg == $past(latch0_reg))
    else $error("port0 latch moved while disabled");
  wide_timer_a: assert property (
    (en0 && mode0 == tpo_pkg::TPO_WIDE_TIMER && i_timer_a_event) |=>
      latch0_reg == $past(i_port0_buffer))
    else $error("wide timer transfer missed");
  split_high_a: assert property (
    (en0 && mode0 == tpo_pkg::TPO_SPLIT_TIMER && i_timer_b_event &&
     !i_timer_a_event) |=>
      latch0_reg == {$past(i_port0_buffer[7:4]), $past(latch0_reg[3:0])})
    else $error("split high transfer wrong");
  wide_ext_a: assert property (
    (en0 && mode0 == tpo_pkg::TPO_WIDE_EXT && ext_event) |=>
      latch0_reg == $past(i_port0_buffer))
    else $error("external trigger transfer missed");
  p1_narrow_a: assert property (
    (en1 && !wide1 && i_timer_c_event) |=>
      latch1_reg == {$past(latch1_reg[5:4]), $past(i_port1_buffer[3:0])})
    else $error("port1 narrow transfer wrong");
  mod_bit0_a: assert property (
    (master && mod_ctl_reg[6] && !inv0) |=>
      o_port0_out_bit[0] == ($past(rtp0_next[0]) | $past(i_mod_timer_out)))
    else $error("bit0 modulation wrong");
  inv_plain_a: assert property (
    (master && inv0 && !mod_ctl_reg[5]) |=>
      o_port0_out_bit[1] == !$past(rtp0_next[1]))
    else $error("bit1 inversion wrong");

endmodule // tpo_core

`default_nettype wire

// File: core/tpo_defines.svh
// Offsets, field positions, widths and reset values of the pattern outputs
// Assumes inclusion by bare name from the package and the design modules
`ifndef TPO_DEFINES_SVH
`define TPO_DEFINES_SVH

`define TPO_ADDR_W           16
`define TPO_DATA_W           8
`define TPO_P0_W             8
`define TPO_P1_W             6
`define TPO_NIB_W            4

`define TPO_ADDR_P0_MOD_CTL  16'hFF28
`define TPO_ADDR_P0_SEL      16'hFFB4
`define TPO_ADDR_P0_CTL      16'hFFB5
`define TPO_ADDR_P1_SEL      16'hFFBC
`define TPO_ADDR_P1_CTL      16'hFFBD

`define TPO_RESET_BYTE       8'h00

// Control register fields
`define TPO_BIT_ENABLE       7
`define TPO_BIT_EXT_EDGE     6
`define TPO_BIT_WIDTH        5
`define TPO_BIT_EXT_SEL      4

// Modulation control fields
`define TPO_BIT_MOD_MASTER   7
`define TPO_BIT_MOD_HIGH     6
`define TPO_BIT_MOD_LOW      5
`define TPO_BIT_INVERT       4

`endif

// File: core/tpo_pkg.sv
// Types shared by the pattern output control block
// Assumes tpo_defines.svh on the include path
`include "tpo_defines.svh"

package tpo_pkg;

  typedef logic [`TPO_DATA_W-1:0] tpo_byte_t;

  // Order follows {port0_width, ext_trigger_select}
  typedef enum logic [1:0] {
    TPO_SPLIT_TIMER,
    TPO_SPLIT_EXT,
    TPO_WIDE_TIMER,
    TPO_WIDE_EXT
  } tpo_p0_mode_e;

endpackage

// File: core/tpo_edge_sync.sv
// Two-stage synchroniser with selectable edge detection for the trigger pin
// Assumes an asynchronous pin and a single system clock
`timescale 1ns/10ps
`default_nettype none

module tpo_edge_sync
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_pin,
  input  wire logic i_rising,
  output var  logic o_event
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic [1:0] fill_reg;

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      fill_reg <= 2'h0;
    end
    else
    begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      if (fill_reg != 2'h3)
        fill_reg <= fill_reg + 2'h1;
    end
  end

  // Edge is judged only on synchronised stages
  // No edge until the stages hold the pin; a pin idling high would
  // otherwise fake a rising edge just after reset
  always_comb
  begin
    if (fill_reg != 2'h3)
      o_event = 1'b0;
    else if (i_rising)
      o_event = sync_reg & ~prev_reg;
    else
      o_event = ~sync_reg & prev_reg;
  end

endmodule // tpo_edge_sync

`default_nettype wire

// File: verification/tpo_load_model.sv
// Load side of the pattern pins: watches them, drives the trigger pin
// Assumes the bench asks for pin levels through i_pin_req
`timescale 1ns/10ps
`default_nettype none

module tpo_load_model
(
  input  wire logic       i_pin_req,
  input  wire logic [7:0] i_port0_out_bit,
  input  wire logic [5:0] i_port1_out_bit,
  output var  logic       o_ext_pin
);
  // Pin moves off the clock grid so the synchroniser is really used
  initial o_ext_pin = 1'b1;
  always @(i_pin_req) o_ext_pin <= #13 i_pin_req;
endmodule // tpo_load_model

`default_nettype wire

// File: verification/triggered_pattern_output_control_tb.sv
// Register-level tests of the pattern output block and its pins
// Assumes tpo_core and tpo_load_model; inputs move at falling edges
`timescale 1ns/10ps
`default_nettype none
`include "tpo_defines.svh"

module triggered_pattern_output_control_tb;
  logic        clk = 1'b0;
  logic        rst;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [15:0] sfr_addr = 16'h0000;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic [7:0]  buf0 = 8'h00;
  logic [5:0]  buf1 = 6'h00;
  logic        tmr_a = 1'b0;
  logic        tmr_b = 1'b0;
  logic        tmr_c = 1'b0;
  logic        pin_req = 1'b1;
  logic        ext_pin;
  logic        wave = 1'b0;
  logic [7:0]  p0;
  logic [7:0]  p0_mode;
  logic [5:0]  p1;
  logic [5:0]  p1_mode;
  int          num_errors = 0;
  int          checks_done = 0;

  always #20 clk = ~clk;

  tpo_core u_dut
  (
    .i_clk            (clk),
    .i_reset          (rst),
    .i_sfr_wr         (sfr_wr),
    .i_sfr_rd         (sfr_rd),
    .i_sfr_addr       (sfr_addr),
    .i_sfr_wdata      (sfr_wdata),
    .o_sfr_rdata      (sfr_rdata),
    .i_port0_buffer   (buf0),
    .i_port1_buffer   (buf1),
    .i_timer_a_event  (tmr_a),
    .i_timer_b_event  (tmr_b),
    .i_timer_c_event  (tmr_c),
    .i_ext_pin        (ext_pin),
    .i_mod_timer_out  (wave),
    .o_port0_out_bit  (p0),
    .o_port0_rtp_mode (p0_mode),
    .o_port1_out_bit  (p1),
    .o_port1_rtp_mode (p1_mode)
  );

  tpo_load_model u_load
  (
    .i_pin_req       (pin_req),
    .i_port0_out_bit (p0),
    .i_port1_out_bit (p1),
    .o_ext_pin       (ext_pin)
  );

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge clk);
    sfr_rd = 1'b0;
    @(negedge clk);
    chk("rdata", exp, sfr_rdata);
  endtask

  // One-cycle event pulse: 0 timer a, 1 timer b, 2 timer c
  task automatic fire(input int which);
    @(negedge clk);
    tmr_a = (which == 0);
    tmr_b = (which == 1);
    tmr_c = (which == 2);
    @(negedge clk);
    {tmr_a, tmr_b, tmr_c} = 3'b000;
    repeat (2) @(negedge clk);
  endtask

  // Sync and edge detect take three edges; eight leaves margin
  task automatic ext(input logic lvl);
    pin_req = lvl;
    repeat (8) @(negedge clk);
  endtask

  task automatic chk0(input logic [7:0] exp);
    chk("port0", exp, p0);
  endtask

  task automatic chk1(input logic [5:0] exp);
    chk("port1", {2'b00, exp}, {2'b00, p1});
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #400000;
    num_errors++;
    end_of_test;
  end

  initial
  begin
    // Set here, not at declaration, so the async reset sees an edge
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rd_chk(`TPO_ADDR_P0_MOD_CTL, 8'h00);
    rd_chk(`TPO_ADDR_P0_CTL, 8'h00);
    rd_chk(`TPO_ADDR_P1_SEL, 8'h00);
    rd_chk(`TPO_ADDR_P1_CTL, 8'h00);
    rd_chk(16'hFF00, 8'h00);
    $display("test reset done");
    wr_reg(`TPO_ADDR_P0_CTL, 8'hFF);
    rd_chk(`TPO_ADDR_P0_CTL, 8'hF0);
    wr_reg(`TPO_ADDR_P1_CTL, 8'hFF);
    rd_chk(`TPO_ADDR_P1_CTL, 8'hA0);
    wr_reg(`TPO_ADDR_P0_MOD_CTL, 8'hFF);
    rd_chk(`TPO_ADDR_P0_MOD_CTL, 8'hF0);
    wr_reg(`TPO_ADDR_P1_SEL, 8'h3F);
    rd_chk(`TPO_ADDR_P1_SEL, 8'h3F);
    wr_reg(`TPO_ADDR_P0_CTL, 8'h00);
    wr_reg(`TPO_ADDR_P1_CTL, 8'h00);
    wr_reg(`TPO_ADDR_P0_MOD_CTL, 8'h00);
    wr_reg(`TPO_ADDR_P0_SEL, 8'hFF);
    chk("port0 mode", 8'hFF, p0_mode);
    $display("test registers done");
    buf0 = 8'hFF;
    buf1 = 6'h3F;
    for (int i = 0; i < 3; i++)
      fire(i);
    chk0(8'h00);
    chk1(6'h00);
    $display("test disabled done");
    wr_reg(`TPO_ADDR_P0_CTL, 8'hA0);
    buf0 = 8'hA5;
    fire(1);
    chk0(8'h00);
    fire(0);
    chk0(8'hA5);
    wr_reg(`TPO_ADDR_P0_SEL, 8'h0F);
    chk0(8'h05);
    wr_reg(`TPO_ADDR_P0_SEL, 8'hFF);
    wr_reg(`TPO_ADDR_P0_CTL, 8'h80);
    buf0 = 8'h3C;
    fire(1);
    chk0(8'h35);
    fire(0);
    chk0(8'h3C);
    $display("test timer modes done");
    wr_reg(`TPO_ADDR_P0_CTL, 8'h90);
    buf0 = 8'h96;
    fire(0);
    chk0(8'h9C);
    ext(1'b0);
    chk0(8'h96);
    buf0 = 8'h00;
    ext(1'b1);
    chk0(8'h96);
    wr_reg(`TPO_ADDR_P0_CTL, 8'hF0);
    buf0 = 8'h5A;
    ext(1'b0);
    chk0(8'h96);
    ext(1'b1);
    chk0(8'h5A);
    buf0 = 8'h00;
    fire(0);
    chk0(8'h5A);
    $display("test external done");
    wave = 1'b1;
    wr_reg(`TPO_ADDR_P0_MOD_CTL, 8'h40);
    chk0(8'h5A);
    wr_reg(`TPO_ADDR_P0_MOD_CTL, 8'hC0);
    chk0(8'h5F);
    wr_reg(`TPO_ADDR_P0_MOD_CTL, 8'hA0);
    chk0(8'h7A);
    wr_reg(`TPO_ADDR_P0_MOD_CTL, 8'hD0);
    chk0(8'hA5);
    wave = 1'b0;
    repeat (2) @(negedge clk);
    chk0(8'hA0);
    wr_reg(`TPO_ADDR_P0_MOD_CTL, 8'h10);
    chk0(8'h5A);
    $display("test modulation done");
    wr_reg(`TPO_ADDR_P1_CTL, 8'h80);
    fire(2);
    chk1(6'h0F);
    wr_reg(`TPO_ADDR_P1_CTL, 8'hA0);
    buf1 = 6'h2A;
    fire(2);
    chk1(6'h2A);
    wr_reg(`TPO_ADDR_P1_SEL, 8'h0F);
    chk1(6'h0A);
    chk("port1 mode", 8'h0F, {2'b00, p1_mode});
    $display("test port1 done");
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd_chk(`TPO_ADDR_P1_CTL, 8'h00);
    rd_chk(`TPO_ADDR_P1_SEL, 8'h00);
    rd_chk(`TPO_ADDR_P0_MOD_CTL, 8'h00);
    chk1(6'h00);
    chk("port1 mode", 8'h00, {2'b00, p1_mode});
    $display("test mid reset done");
    end_of_test;
  end
endmodule // triggered_pattern_output_control_tb

`default_nettype wire
